//--- inc/dcw_pkg.sv
// constants, field layout and types for the decimal control word decoder
// assumes a 125 MHz single clock and an avalon-mm register slave
package dcw_pkg;

   // ---------------------------------------------------------------
   // register map, byte offsets, one 32-bit word each
   // ---------------------------------------------------------------
   localparam logic [7:0]  OFS_CTRL_WORD = 8'h00;
   localparam logic [7:0]  OFS_CMD       = 8'h04;
   localparam logic [7:0]  OFS_SRC_BASE  = 8'h08;
   localparam logic [7:0]  OFS_DST_BASE  = 8'h0c;
   localparam logic [7:0]  OFS_STATUS    = 8'h10;
   localparam logic [31:0] RST_WORD      = 32'h0000_0000;

   // command register fields
   localparam int CMD_OP_LSB   = 0;   // [2:0] instruction select
   localparam int CMD_NEWER    = 8;   // processor in a newer addressing mode
   localparam int CMD_GO       = 31;  // write one to decode

   // ---------------------------------------------------------------
   // control word fields, bit 1 of the word is bit 31 here
   // ---------------------------------------------------------------
   localparam int CW_SRC_LEN_LSB = 26;  // [31:26]
   localparam int CW_SRC_NEG     = 23;
   localparam int CW_DST_NEG     = 22;
   localparam int CW_FORCE_POS   = 20;
   localparam int CW_ROUND       = 19;
   localparam int CW_SRC_TYP_LSB = 16;  // [18:16]
   localparam int CW_DST_LEN_LSB = 10;  // [15:10]
   localparam int CW_SCALE_LSB   = 3;   // [9:3]
   localparam int CW_DST_TYP_LSB = 0;   // [2:0]
   localparam int LEN_W          = 6;
   localparam int SCALE_W        = 7;

   // digit widths in bits
   localparam logic [3:0] UNPACKED_DIGIT_BITS = 4'h8;
   localparam logic [3:0] PACKED_DIGIT_BITS   = 4'h4;

   typedef enum logic [2:0] {
      decimal_add_op, decimal_multiply_op, decimal_divide_op, decimal_move_op,
      decimal_compare_op, decimal_edit_op, binary_to_decimal_op, decimal_to_binary_op
   } dcw_op_t;

   typedef enum logic [2:0] {
      LEAD_SEP  = 3'h0,
      TRAIL_SEP = 3'h1,
      PACKED    = 3'h3,
      LEAD_EMB  = 3'h4,
      TRAIL_EMB = 3'h5
   } dcw_ftype_t;

   // alu decimal modes carried by a microinstruction
   localparam logic [1:0] MODE_ADJUST = 2'h0;
   localparam logic [1:0] MODE_OBTAIN = 2'h1;
   localparam logic [1:0] unpack_to_pack_mode   = 2'h2;
   localparam logic [1:0] unpack_to_unpack_mode = 2'h3;

   // obtain table, entry {dst_align, count} at bits [2i+1:2i]
   localparam logic [31:0] OBTAIN_TABLE = {
      2'h3, 2'h2, 2'h1, 2'h0,  2'h0, 2'h3, 2'h2, 2'h0,
      2'h3, 2'h0, 2'h3, 2'h0,  2'h1, 2'h0, 2'h0, 2'h0 };

   typedef struct packed {
      logic [LEN_W-1:0]   src_len;
      logic [LEN_W-1:0]   dst_len;
      logic               src_neg;
      logic               dst_neg;
      logic               force_pos;
      logic               round;
      logic [SCALE_W-1:0] scale;
   } dcw_fields_t;

   typedef struct packed {
      logic               legal;       // encoding is one of the five types
      logic               trailing;
      logic               packed_fmt;
      logic               embedded;
      logic [3:0]         digit_bits;
      logic [LEN_W-1:0]   ls_offset;   // byte offset of least significant digit
      logic [1:0]         ls_align;    // byte lane of that digit
   } dcw_fmt_t;

   typedef struct packed {
      logic               uc_mode_valid;  // microinstruction carries an alu decimal mode
      logic [1:0]         uc_mode;
      logic               uc_jump;        // jump microinstruction samples the condition
      logic [1:0]         uc_count;       // remaining data count, low bits
   } dcw_uc_t;

endpackage

//--- verilog/dcw_decode.sv
// decimal control word decoder and decimal jump condition generator
// assumes one 125 MHz clock, avalon-mm master on the register side and
// the microcode sequencer on the same clock driving the uc inputs
//
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none

// How it works
// (RULE_01) decode only in the two newer modes
// (RULE_02) software loads control word before instruction
// (RULE_03) extract source and destination digit lengths
// (RULE_04) source negation always, destination negation selectively
// (RULE_05) force positive for add, multiply, divide, move
// (RULE_06) round flag only for move
// (RULE_07) scale differential only add, move, compare
// (RULE_08) decode five field type encodings
// (RULE_09) software gives odd count for packed
// (RULE_10) low bit trailing or packed, high embedded
// (RULE_11) unpacked byte digits, packed nibble digits
// (RULE_12) unpack on entry, pack back on store; code sets both flags for unpacked fields, not packed
// (RULE_13) most significant digit at lowest address
// (RULE_14) process from highest address downward
// (RULE_15) alignment names least significant digit byte
// (RULE_16) jump bits follow preceding microinstruction mode
// (RULE_17) adjust mode uses destination alignment only
// (RULE_18) obtain uses destination alignment and count
// (RULE_19) unpack-to-pack uses source and destination alignment
// (RULE_20) unpack-to-unpack uses source alignment only
// (RULE_21) mode 00 gives destination alignment code
// (RULE_22) obtain is 01, conversions 10, 11
// (RULE_23) jump bits held until jump samples
module dcw_decode (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [7:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [31:0]          avs_writedata,
   input  wire logic [3:0]           avs_byteenable,
   output var  logic [31:0]          avs_readdata,
   output var  logic                 avs_waitrequest,
   input  wire dcw_pkg::dcw_uc_t     uc,
   output var  logic                 dec_start,
   output var  logic                 dec_illegal,
   output var  dcw_pkg::dcw_op_t     dec_op,
   output var  dcw_pkg::dcw_fields_t dec_fields,
   output var  dcw_pkg::dcw_fmt_t    dec_src_fmt,
   output var  dcw_pkg::dcw_fmt_t    dec_dst_fmt,
   output var  logic                 unpack_on_entry,
   output var  logic                 pack_on_store,
   output var  logic [31:0]          src_ls_addr,
   output var  logic [31:0]          dst_ls_addr,
   output var  logic                 walk_down,
   output var  logic [1:0]           decimal_jump_cond
);
   import dcw_pkg::*;

   // ---------------------------------------------------------------
   // functions
   // ---------------------------------------------------------------

   // field type and length to format; used for source and destination
   function automatic dcw_fmt_t field_fmt(input logic [2:0] typ, input logic [LEN_W-1:0] len,
                                          input logic [31:0] base);
      dcw_fmt_t   f;
      logic [31:0] ls;
      f = '0;
      f.legal      = (typ == LEAD_SEP) || (typ == TRAIL_SEP) || (typ == PACKED)
                     || (typ == LEAD_EMB) || (typ == TRAIL_EMB);          // [RULE_08]
      f.trailing   = typ[0] && !(typ == PACKED);                          // [RULE_10]
      f.packed_fmt = (typ == PACKED);                                     // [RULE_10]
      f.embedded   = typ[2];                                              // [RULE_10]
      f.digit_bits = f.packed_fmt ? PACKED_DIGIT_BITS : UNPACKED_DIGIT_BITS; // [RULE_11]
      // msd sits at base, so the lsd byte is the last one of the field
      if (f.packed_fmt) begin
         f.ls_offset = len >> 1;                                          // [RULE_13]
      end else begin
         f.ls_offset = (len == '0) ? '0 : len - 1'b1;                     // [RULE_13]
      end
      ls = base + {{(32-LEN_W){1'b0}}, f.ls_offset};
      f.ls_align = ls[1:0];                                               // [RULE_15]
      return f;
   endfunction

   // byte-enable merge for register writes
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   // ---------------------------------------------------------------
   // avalon slave: one wait state, answer on the second edge
   // ---------------------------------------------------------------
   logic        req;
   logic        take;
   logic [31:0] ctrl_word;
   logic [31:0] cmd;
   logic [31:0] src_base;
   logic [31:0] dst_base;
   logic        st_valid;
   logic        st_illegal;
   logic        st_bad_len;
   logic [31:0] next_readdata;

   assign req  = avs_read || avs_write;
   assign take = req && !avs_waitrequest;

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !(req && avs_waitrequest);
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      next_readdata = '0;
      case (avs_address)
         OFS_CTRL_WORD: next_readdata = ctrl_word;
         OFS_CMD:       next_readdata = {1'b0, cmd[30:0]};
         OFS_SRC_BASE:  next_readdata = src_base;
         OFS_DST_BASE:  next_readdata = dst_base;
         OFS_STATUS:    next_readdata = {26'h0, decimal_jump_cond, st_bad_len, st_illegal, st_valid, 1'b0};
         default:       next_readdata = '0;
      endcase
   end

   // read data captured while waiting, stands at the answer edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         avs_readdata <= RST_WORD;
      end else if (avs_read && avs_waitrequest) begin
         avs_readdata <= next_readdata;
      end
   end

   // register writes take effect only at the answer edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_word <= RST_WORD;
         cmd       <= RST_WORD;
         src_base  <= RST_WORD;
         dst_base  <= RST_WORD;
      end else if (take && avs_write) begin
         case (avs_address)
            OFS_CTRL_WORD: ctrl_word <= be_merge(ctrl_word, avs_writedata, avs_byteenable); // [RULE_02]
            OFS_CMD:       cmd       <= be_merge(cmd, avs_writedata, avs_byteenable);
            OFS_SRC_BASE:  src_base  <= be_merge(src_base, avs_writedata, avs_byteenable);
            OFS_DST_BASE:  dst_base  <= be_merge(dst_base, avs_writedata, avs_byteenable);
            default: ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // decode request
   // ---------------------------------------------------------------
   logic go;
   logic go_q;

   // go byte must be enabled; the go bit is stored but always reads back zero
   assign go = take && avs_write && (avs_address == OFS_CMD)
               && avs_byteenable[3] && avs_writedata[CMD_GO];

   // one cycle delay so the freshly written command is in cmd
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         go_q <= 1'b0;
      end else begin
         go_q <= go;
      end
   end

   // ---------------------------------------------------------------
   // control word decode
   // ---------------------------------------------------------------
   dcw_op_t     op;
   logic        is_add;
   logic        is_mul;
   logic        is_div;
   logic        is_mov;
   logic        is_cmp;
   logic        newer_mode;
   dcw_fields_t next_fields;
   dcw_fmt_t    next_src_fmt;
   dcw_fmt_t    next_dst_fmt;

   assign op         = dcw_op_t'(cmd[CMD_OP_LSB +: 3]);
   assign newer_mode = cmd[CMD_NEWER];
   assign is_add     = (op == decimal_add_op);
   assign is_mul     = (op == decimal_multiply_op);
   assign is_div     = (op == decimal_divide_op);
   assign is_mov     = (op == decimal_move_op);
   assign is_cmp     = (op == decimal_compare_op);

   // field extraction with per-instruction gating; ignored flags read zero
   always_comb begin
      next_fields           = '0;
      next_fields.src_len   = ctrl_word[CW_SRC_LEN_LSB +: LEN_W];                   // [RULE_03]
      next_fields.dst_len   = ctrl_word[CW_DST_LEN_LSB +: LEN_W];                   // [RULE_03]
      next_fields.src_neg   = ctrl_word[CW_SRC_NEG];                                // [RULE_04]
      next_fields.dst_neg   = ctrl_word[CW_DST_NEG]
                              && (is_add || is_mul || is_div || is_cmp);            // [RULE_04]
      next_fields.force_pos = ctrl_word[CW_FORCE_POS]
                              && (is_add || is_mul || is_div || is_mov);            // [RULE_05]
      next_fields.round     = ctrl_word[CW_ROUND] && is_mov;                        // [RULE_06]
      next_fields.scale     = (is_add || is_mov || is_cmp)
                              ? ctrl_word[CW_SCALE_LSB +: SCALE_W] : '0;            // [RULE_07]
   end

   assign next_src_fmt = field_fmt(ctrl_word[CW_SRC_TYP_LSB +: 3], ctrl_word[CW_SRC_LEN_LSB +: LEN_W],
                                   src_base);
   assign next_dst_fmt = field_fmt(ctrl_word[CW_DST_TYP_LSB +: 3], ctrl_word[CW_DST_LEN_LSB +: LEN_W],
                                   dst_base);

   // decoded outputs load only when the mode allows the instruction
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dec_op          <= decimal_add_op;
         dec_fields      <= '0;
         dec_src_fmt     <= '0;
         dec_dst_fmt     <= '0;
         unpack_on_entry <= 1'b0;
         pack_on_store   <= 1'b0;
         src_ls_addr     <= RST_WORD;
         dst_ls_addr     <= RST_WORD;
         walk_down       <= 1'b0;
      end else if (go_q && newer_mode) begin                                         // [RULE_01]
         dec_op          <= op;
         dec_fields      <= next_fields;
         dec_src_fmt     <= next_src_fmt;
         dec_dst_fmt     <= next_dst_fmt;
         unpack_on_entry <= !next_src_fmt.packed_fmt;                               // [RULE_12]
         pack_on_store   <= !next_dst_fmt.packed_fmt;                               // [RULE_12]
         src_ls_addr     <= src_base + {26'h0, next_src_fmt.ls_offset};             // [RULE_14]
         dst_ls_addr     <= dst_base + {26'h0, next_dst_fmt.ls_offset};             // [RULE_14]
         walk_down       <= 1'b1;                                                   // [RULE_14]
      end
   end

   // start and illegal pulses, one cycle each
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dec_start   <= 1'b0;
         dec_illegal <= 1'b0;
      end else begin
         dec_start   <= go_q && newer_mode;                                         // [RULE_01]
         dec_illegal <= go_q && !newer_mode;                                        // [RULE_01]
      end
   end

   // status flags follow the latest decode request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_valid   <= 1'b0;
         st_illegal <= 1'b0;
         st_bad_len <= 1'b0;
      end else if (go_q) begin
         st_valid   <= newer_mode && next_src_fmt.legal && next_dst_fmt.legal;
         st_illegal <= !newer_mode;
         // even packed count is a software fault; flagged, not trapped
         st_bad_len <= (next_src_fmt.packed_fmt && !next_fields.src_len[0])
                       || (next_dst_fmt.packed_fmt && !next_fields.dst_len[0]);     // [RULE_09]
      end
   end

   // ---------------------------------------------------------------
   // decimal jump conditions
   // ---------------------------------------------------------------
   logic [1:0] src_al;
   logic [1:0] dst_al;
   logic [1:0] next_cond;
   logic [4:0] obt_idx;

   assign src_al  = dec_src_fmt.ls_align;                                           // [RULE_15]
   assign dst_al  = dec_dst_fmt.ls_align;                                           // [RULE_15]
   assign obt_idx = {dst_al, uc.uc_count, 1'b0};                                    // entry i at bit 2i

   // per-mode selection of the condition inputs
   always_comb begin
      next_cond = 2'h0;
      case (uc.uc_mode)
         MODE_ADJUST:           next_cond = dst_al;                                  // [RULE_17] [RULE_21]
         MODE_OBTAIN:           next_cond = OBTAIN_TABLE[obt_idx +: 2];              // [RULE_18] [RULE_22]
         unpack_to_pack_mode:   next_cond = dst_al - src_al;                         // [RULE_19] [RULE_22]
         unpack_to_unpack_mode: next_cond = src_al;                                  // [RULE_20] [RULE_22]
         default:               next_cond = 2'h0;
      endcase
   end

   // loads only on a mode-bearing microinstruction, so it holds through the jump
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         decimal_jump_cond <= 2'h0;
      end else if (uc.uc_mode_valid) begin
         decimal_jump_cond <= next_cond;                                             // [RULE_16] [RULE_23]
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_go_new;
      go && avs_writedata[CMD_NEWER] && avs_byteenable[1] ##1 1'b1;
   endsequence

   sequence s_mode_adjust;
      uc.uc_mode_valid && uc.uc_mode == MODE_ADJUST;
   endsequence

   chk_illegal_mode_blocks: assert property (@(posedge clk) disable iff (!rst_n)  // [RULE_01]
      go_q && !newer_mode |=> !dec_start && dec_illegal && $stable(dec_fields))
      else $error("decode accepted outside newer mode");

   chk_go_to_start: assert property (@(posedge clk) disable iff (!rst_n)          // [RULE_01]
      s_go_new |-> ##1 dec_start)
      else $error("start pulse missing two cycles after go");

   chk_src_len_copy: assert property (@(posedge clk) disable iff (!rst_n)         // [RULE_03]
      dec_start |-> dec_fields.src_len == $past(ctrl_word[CW_SRC_LEN_LSB +: LEN_W]))
      else $error("source length not taken from control word");

   chk_dst_neg_gate: assert property (@(posedge clk) disable iff (!rst_n)         // [RULE_04]
      dec_start && (dec_op == decimal_move_op || dec_op == decimal_edit_op) |-> !dec_fields.dst_neg)
      else $error("destination negation honoured for wrong op");

   chk_force_pos_gate: assert property (@(posedge clk) disable iff (!rst_n)       // [RULE_05]
      dec_start && dec_op == decimal_compare_op |-> !dec_fields.force_pos)
      else $error("force positive honoured for compare");

   chk_round_move_only: assert property (@(posedge clk) disable iff (!rst_n)      // [RULE_06]
      dec_start && dec_fields.round |-> dec_op == decimal_move_op)
      else $error("round flag outside move");

   chk_scale_gate: assert property (@(posedge clk) disable iff (!rst_n)          // [RULE_07]
      dec_start && dec_fields.scale != '0 |->
      dec_op inside {decimal_add_op, decimal_move_op, decimal_compare_op})
      else $error("scale used by wrong op");

   chk_digit_width: assert property (@(posedge clk) disable iff (!rst_n)         // [RULE_11]
      dec_start |-> dec_src_fmt.digit_bits == (dec_src_fmt.packed_fmt ? 4'h4 : 4'h8)
                    && unpack_on_entry == !dec_src_fmt.packed_fmt)
      else $error("digit width or unpack flag wrong");

   chk_adjust_cond: assert property (@(posedge clk) disable iff (!rst_n)         // [RULE_21]
      s_mode_adjust |=> decimal_jump_cond == $past(dec_dst_fmt.ls_align))
      else $error("adjust condition not destination alignment");

   chk_cond_held: assert property (@(posedge clk) disable iff (!rst_n)           // [RULE_23]
      !uc.uc_mode_valid |=> $stable(decimal_jump_cond))
      else $error("jump condition moved without a mode");

   chk_u2u_src_align: assert property (@(posedge clk) disable iff (!rst_n)         // [RULE_20]
      uc.uc_mode_valid && uc.uc_mode == unpack_to_unpack_mode |=> decimal_jump_cond == $past(dec_src_fmt.ls_align))
      else $error("unpack to unpack condition not source alignment");

   chk_u2p_both_align: assert property (@(posedge clk) disable iff (!rst_n)        // [RULE_19]
      uc.uc_mode_valid && uc.uc_mode == unpack_to_pack_mode
      |=> 2'(decimal_jump_cond + $past(dec_src_fmt.ls_align)) == $past(dec_dst_fmt.ls_align))
      else $error("unpack to pack condition not alignment difference");

   chk_walk_set: assert property (@(posedge clk) disable iff (!rst_n)              // [RULE_14]
      dec_start |-> walk_down)
      else $error("accepted decode without downward walk");

   chk_wait_one: assert property (@(posedge clk) disable iff (!rst_n)
      req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not a single low cycle");

endmodule
`default_nettype wire

//--- sim/dcw_useq.sv
// sequencer model: issues alu decimal modes, then a jump one cycle later
// assumes the decoder samples uc on the rising edge of clk
`timescale 1ns/10ps
`default_nettype none
module dcw_useq (
   input  wire logic             clk,
   output var  dcw_pkg::dcw_uc_t uc
);
   import dcw_pkg::*;
   initial uc = '0;
   // mode word, then jump with junk mode bits
   task automatic issue(input logic [1:0] mode, input logic [1:0] cnt);
      @(posedge clk);
      uc <= '{1'b1, mode, 1'b0, cnt};
      @(posedge clk);
      uc <= '{1'b0, ~mode, 1'b1, ~cnt};
      @(posedge clk);
      uc <= '0;
   endtask
endmodule
`default_nettype wire

//--- sim/decimal_control_word_decode_test.sv
// self-checking bench for the decimal control word decoder
// assumes dcw_pkg is compiled first and dcw_useq drives the uc inputs
`timescale 1ns/10ps
`default_nettype none
module decimal_control_word_decode_test;
   import dcw_pkg::*;
   logic clk, rst_n, avs_read, avs_write, avs_waitrequest, dec_start, dec_illegal;
   logic unpack_on_entry, pack_on_store, walk_down;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, src_ls_addr, dst_ls_addr, rd;
   logic [3:0] avs_byteenable;
   logic [1:0] decimal_jump_cond;
   dcw_uc_t uc;
   dcw_op_t dec_op;
   dcw_fields_t dec_fields;
   dcw_fmt_t dec_src_fmt, dec_dst_fmt;
   int num_errors, n_compared;
   // rows: op, then expected dst_neg, force_pos, round, scale kept
   logic [6:0] rows [8] = '{7'h0d, 7'h1c, 7'h2c, 7'h37, 7'h49, 7'h50, 7'h60, 7'h70};
   int ty [5] = '{0, 1, 3, 4, 5};
   // jump rows: mode, count, expected; each load changes the condition
   logic [5:0] jrows [7] = '{6'h03, 6'h10, 6'h22, 6'h15, 6'h1f, 6'h31, 6'h1a};
   dcw_decode u_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .uc(uc), .dec_start(dec_start),
      .dec_illegal(dec_illegal), .dec_op(dec_op), .dec_fields(dec_fields), .dec_src_fmt(dec_src_fmt),
      .dec_dst_fmt(dec_dst_fmt), .unpack_on_entry(unpack_on_entry), .pack_on_store(pack_on_store),
      .src_ls_addr(src_ls_addr), .dst_ls_addr(dst_ls_addr), .walk_down(walk_down),
      .decimal_jump_cond(decimal_jump_cond));
   dcw_useq u_seq (.clk(clk), .uc(uc));
   // ---------------------------------------------------------------
   // clock and shared tasks
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // raised after an edge, held to the edge ending the low waitrequest; only the watchdog ends a wait
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_write <= wr;
      avs_read <= !wr;
      avs_address <= a;
      avs_writedata <= d;
      do begin
         @(negedge clk);
      end while (avs_waitrequest !== 1'b0);
      @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic go(input logic [31:0] cmd);
      int n;
      bus(1'b1, OFS_CMD, cmd);
      n = 0;
      while (dec_start !== 1'b1 && dec_illegal !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk("decode_done", 1, dec_start | dec_illegal);
   endtask
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // watchdog, far beyond the roughly 150 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      conclude();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 8'h00;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("waitrequest", 1, avs_waitrequest);
      chk("jump_idle", 0, decimal_jump_cond);
      @(posedge clk);
      bus(1'b1, OFS_SRC_BASE, 32'h0000_0101);
      bus(1'b1, OFS_DST_BASE, 32'h0000_0203);
      bus(1'b1, OFS_CTRL_WORD, 32'h14d8_0428);
      for (int i = 0; i < 8; i++) begin
         go(32'h8000_0100 | rows[i][6:4]);
         chk("start", 1, dec_start);
         chk("op", rows[i][6:4], dec_op);
         chk("fields", {6'h05, 6'h01, 1'b1, rows[i][3:1], rows[i][0] ? 7'h05 : 7'h00}, 32'(dec_fields));
      end
      chk("src_ls", 32'h105, src_ls_addr);
      chk("dst_ls", 32'h203, dst_ls_addr);
      chk("convert", 3, {unpack_on_entry, pack_on_store});
      chk("digit", 8, dec_src_fmt.digit_bits);
      chk("walk", 1, walk_down);
      $display("field gating test done");
      for (int m = 0; m < 7; m++) begin
         u_seq.issue(jrows[m][5:4], jrows[m][3:2]);
         repeat (3) @(negedge clk);
         chk("jump", jrows[m][1:0], decimal_jump_cond);
      end
      $display("jump condition test done");
      foreach (ty[k]) begin
         bus(1'b1, OFS_CTRL_WORD, 32'h1400_0400 | ty[k]);
         go(32'h8000_0103);
         chk("dtype", {1'b1, ty[k] == 3, ty[k][2], ty[k][0] && ty[k] != 3}, {dec_dst_fmt.legal,
            dec_dst_fmt.packed_fmt, dec_dst_fmt.embedded, dec_dst_fmt.trailing});
      end
      bus(1'b1, OFS_CTRL_WORD, 32'h1403_0c05);
      go(32'h8000_0103);
      chk("src_fmt", {4'b1010, 4'h4, 6'h02, 2'h3}, dec_src_fmt);
      chk("dst_fmt", {4'b1101, 4'h8, 6'h02, 2'h1}, dec_dst_fmt);
      chk("unpack", 0, unpack_on_entry);
      chk("src_ls_p", 32'h103, src_ls_addr);
      $display("format test done");
      go(32'h8000_0004);
      chk("illegal", 1, dec_illegal);
      chk("op_kept", 3, dec_op);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", 1, rd[2]);
      chk("bad_len", 0, rd[3]);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 0, rd);
      $display("refusal test done");
      conclude();
   end
endmodule
`default_nettype wire
